// >>> core/alsel_defs.svh
// register offsets, field positions, reset values and timing counts for the alarm/select block
// assumes inclusion by the top module only; alsel_pkg does not include it
`ifndef ALSEL_DEFS_SVH
`define ALSEL_DEFS_SVH
`define ALSEL_OFF_STATUS 8'h4F
`define ALSEL_OFF_SELECT 8'h50
`define ALSEL_OFF_CTRL 8'h60
`define ALSEL_OFF_SEQ 8'h61
`define ALSEL_OFF_DATA0 8'h70
`define ALSEL_STATUS_RST 16'h0000
`define ALSEL_SELECT_RST 16'h0000
`define ALSEL_CTRL_RST 16'h0000
`define ALSEL_SELECT_MASK 16'h7FFF
`define ALSEL_BIT_A_UNDER 8
`define ALSEL_BIT_A_OVER 7
`define ALSEL_BIT_B_UNDER 6
`define ALSEL_BIT_B_OVER 5
`define ALSEL_BIT_A_FAULT 4
`define ALSEL_BIT_B_FAULT 3
`define ALSEL_BIT_OVERHEAT 2
`define ALSEL_SEL_IN0 14
`define ALSEL_SEL_IN1 13
`define ALSEL_SEL_DIFF01 12
`define ALSEL_SEL_IN2 11
`define ALSEL_SEL_IN3 10
`define ALSEL_SEL_DIFF23 9
`define ALSEL_CTRL_A_EN 0
`define ALSEL_CTRL_B_EN 1
`define ALSEL_CTRL_LT_EN 2
`define ALSEL_CTRL_HOLD_OFF 3
`define ALSEL_CTRL_START 4
`define ALSEL_TRIP_DEGC 12'sd150
`define ALSEL_HYST_DEGC 12'sd8
`define ALSEL_RELEASE_DEGC (`ALSEL_TRIP_DEGC - `ALSEL_HYST_DEGC)
`define ALSEL_CONSEC_N 4'd4
`endif

// >>> core/alsel_pkg.sv
// types shared by the alarm/select block
package alsel_pkg;
    typedef enum logic [1:0] {
        ALSEL_IDLE = 2'b00,
        ALSEL_SCAN = 2'b01,
        ALSEL_WAIT = 2'b10
    } alsel_state_e;
    typedef logic [3:0] alsel_slot_t;
endpackage

// >>> core/alsel_top.sv
// alarm status word, input selection word and conversion sequencer, Wishbone classic slave
// assumes the converter and sensor front ends answer on CLK; pins pass two flip-flops first
//
// Summary of operation
// - status bit 8 shows remote sensor A below its low bound.
// - status bit 7 shows remote sensor A above its high bound.
// - status bit 6 shows remote sensor B below its low bound.
// - status bit 5 shows remote sensor B above its high bound.
// - status bit 4 shows remote sensor A open or shorted.
// - status bit 3 shows remote sensor B open or shorted.
// - sensor A flags are evaluated only while sensor A is enabled.
// - sensor B flags are evaluated only while sensor B is enabled.
// - status bit 2 sets when die temperature reaches 150 degrees.
// - die alarm releases only 8 degrees below the trip point.
// - die alarm stays zero while the on-chip sensor is disabled.
// - status bits 1, 0 and select bit 15 read zero, ignore writes.
// - selected inputs convert in order from bit 14 down to bit 0.
// - single-ended results go to their own data register, straight binary.
// - pair zero/one converts in0 minus in1 into data 0, twos complement.
// - pair two/three converts in2 minus in3 into data 2, twos complement.
// - bits 14 or 13 set make inputs 0/1 single-ended and ignore bit 12.
// - bits 11 or 10 set make inputs 2/3 single-ended and ignore bit 9.
// - a remote sensor alarm sets only after N consecutive out-of-range checks.
// - latched alarms hold until condition ends and status is read.
// - with hold-off set, remote sensor alarms clear as soon as the condition ends.
`timescale 1ns/1ns
`include "alsel_defs.svh"
module alsel_top
    import alsel_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // wishbone classic slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // sensor condition pins, one check per SENSE_STROBE; die temperature checked every clock
    input wire logic SENSE_STROBE,
    input wire logic A_UNDER,
    input wire logic A_OVER,
    input wire logic A_FAULT,
    input wire logic B_UNDER,
    input wire logic B_OVER,
    input wire logic B_FAULT,
    input wire logic [11:0] DIE_TEMP,
    // converter handshake
    output logic CONV_START,
    output logic [3:0] CONV_POS,
    output logic [3:0] CONV_NEG,
    output logic CONV_DIFF,
    input wire logic CONV_DONE,
    input wire logic [11:0] CONV_RESULT,
    // status of sequencer
    output logic SEQ_BUSY
);
    // two-flop synchronisers for pin inputs
    logic [6:0] pin_s1_q, pin_s2_q;
    logic [11:0] temp_s1_q, temp_s2_q, temp_s3_q;
    logic temp_steady;
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            pin_s1_q <= 7'h00;
            pin_s2_q <= 7'h00;
        end else begin
            pin_s1_q <= {SENSE_STROBE, B_FAULT, B_OVER, B_UNDER, A_FAULT, A_OVER, A_UNDER};
            pin_s2_q <= pin_s1_q;
        end
    end
    // the temperature word crosses with no handshake: a value is used only once two
    // successive synchronised samples agree, so a word caught mid-change never trips
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            temp_s1_q <= 12'h000;
            temp_s2_q <= 12'h000;
            temp_s3_q <= 12'h000;
        end else begin
            temp_s1_q <= DIE_TEMP;
            temp_s2_q <= temp_s1_q;
            temp_s3_q <= temp_s2_q;
        end
    end
    assign temp_steady = temp_s2_q == temp_s3_q;

    // bus decode; ack is registered, so the strobe still held in the ack cycle is masked
    // and a request is taken exactly once
    logic [31:0] dat_d, dat_q;
    logic ack_d, ack_q;
    logic bus_req, wr_sel, wr_ctl, rd_status;
    logic [15:0] sel_d, sel_q, ctl_d, ctl_q;
    logic [15:0] status_word;
    logic [15:0] data_q [0:12];
    alsel_state_e st_d, st_q;
    logic [3:0] slot_d, slot_q;
    assign bus_req = WB_CYC_I && WB_STB_I && !ack_q;
    assign wr_sel = bus_req && WB_WE_I && WB_ADR_I == `ALSEL_OFF_SELECT;
    assign wr_ctl = bus_req && WB_WE_I && WB_ADR_I == `ALSEL_OFF_CTRL;
    assign rd_status = bus_req && !WB_WE_I && WB_ADR_I == `ALSEL_OFF_STATUS;

    function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0] sel);
        lane_merge = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
    endfunction

    always_comb begin
        sel_d = sel_q;
        ctl_d = ctl_q;
        ctl_d[`ALSEL_CTRL_START] = 1'b0;
        if (wr_sel) begin
            sel_d = lane_merge(sel_q, WB_DAT_I, WB_SEL_I) & `ALSEL_SELECT_MASK;
        end
        if (wr_ctl) begin
            ctl_d = lane_merge(ctl_q, WB_DAT_I, WB_SEL_I) & 16'h001F;
        end
        ack_d = bus_req;
        dat_d = 32'h0000_0000;
        if (bus_req && !WB_WE_I) begin
            unique case (WB_ADR_I)
                `ALSEL_OFF_STATUS: dat_d = {16'h0000, status_word};
                `ALSEL_OFF_SELECT: dat_d = {16'h0000, sel_q};
                `ALSEL_OFF_CTRL: dat_d = {16'h0000, ctl_q};
                `ALSEL_OFF_SEQ: dat_d = {28'h0000000, slot_q};
                default: begin
                    // unmapped addresses read zero
                    if (WB_ADR_I >= `ALSEL_OFF_DATA0 && WB_ADR_I <= `ALSEL_OFF_DATA0 + 8'h0C) begin
                        dat_d = {16'h0000, data_q[4'(WB_ADR_I - `ALSEL_OFF_DATA0)]};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            sel_q <= `ALSEL_SELECT_RST;
            ctl_q <= `ALSEL_CTRL_RST;
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            sel_q <= sel_d;
            ctl_q <= ctl_d;
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end
    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = dat_q;

    // alarm evaluation: raw conditions gated by enables
    logic [5:0] raw_cond;
    logic a_en, b_en, lt_en, hold_off, strobe_rise, strobe_old_q;
    logic therm_d, therm_q;
    assign a_en = ctl_q[`ALSEL_CTRL_A_EN];
    assign b_en = ctl_q[`ALSEL_CTRL_B_EN];
    assign lt_en = ctl_q[`ALSEL_CTRL_LT_EN];
    assign hold_off = ctl_q[`ALSEL_CTRL_HOLD_OFF];
    // index 5..0 = status bits 8..3
    assign raw_cond = {pin_s2_q[0] & a_en, pin_s2_q[1] & a_en,
                       pin_s2_q[3] & b_en, pin_s2_q[4] & b_en,
                       pin_s2_q[2] & a_en, pin_s2_q[5] & b_en};
    assign strobe_rise = pin_s2_q[6] && !strobe_old_q;

    // a saturated count re-sets its bit at every check while the condition lasts
    logic [3:0] cnt_d [0:5];
    logic [3:0] cnt_q [0:5];
    logic [5:0] alarm_d, alarm_q;
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_alarm
            always_comb begin
                cnt_d[gi] = cnt_q[gi];
                alarm_d[gi] = alarm_q[gi];
                if (strobe_rise) begin
                    if (!raw_cond[gi]) begin
                        cnt_d[gi] = 4'h0;
                    end else if (cnt_q[gi] != `ALSEL_CONSEC_N) begin
                        cnt_d[gi] = cnt_q[gi] + 4'h1;
                    end
                end
                if (hold_off && !raw_cond[gi]) begin
                    alarm_d[gi] = 1'b0;
                end else if (!hold_off && rd_status && !raw_cond[gi]) begin
                    alarm_d[gi] = 1'b0;
                end
                // set only by a check; a set wins over a clear in the same cycle
                if (strobe_rise && cnt_d[gi] == `ALSEL_CONSEC_N) begin
                    alarm_d[gi] = 1'b1;
                end
            end
            always_ff @(posedge CLK or negedge NRST) begin
                if (!NRST) begin
                    cnt_q[gi] <= 4'h0;
                    alarm_q[gi] <= 1'b0;
                end else begin
                    cnt_q[gi] <= cnt_d[gi];
                    alarm_q[gi] <= alarm_d[gi];
                end
            end
        end
    endgenerate

    // the flag holds between the trip and release points, which gives the hysteresis
    always_comb begin
        therm_d = therm_q;
        if (!lt_en) begin
            therm_d = 1'b0;
        end else if (temp_steady && $signed(temp_s2_q) >= `ALSEL_TRIP_DEGC) begin
            therm_d = 1'b1;
        end else if (temp_steady && $signed(temp_s2_q) <= `ALSEL_RELEASE_DEGC) begin
            therm_d = 1'b0;
        end
    end
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            therm_q <= 1'b0;
        end else begin
            therm_q <= therm_d;
        end
    end
    // strobe edge detector; idles low like the pin, so no false check follows reset
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            strobe_old_q <= 1'b0;
        end else begin
            strobe_old_q <= pin_s2_q[6];
        end
    end

    // status word: bits 15..9 belong to other monitors, bits 1..0 are reserved
    always_comb begin
        status_word = `ALSEL_STATUS_RST;
        status_word[`ALSEL_BIT_A_UNDER] = alarm_q[5];
        status_word[`ALSEL_BIT_A_OVER] = alarm_q[4];
        status_word[`ALSEL_BIT_B_UNDER] = alarm_q[3];
        status_word[`ALSEL_BIT_B_OVER] = alarm_q[2];
        status_word[`ALSEL_BIT_A_FAULT] = alarm_q[1];
        status_word[`ALSEL_BIT_B_FAULT] = alarm_q[0];
        status_word[`ALSEL_BIT_OVERHEAT] = therm_q;
    end

    // a select write during a run changes which of the remaining slots are visited
    // conversion sequencer; slot k walks select bit 14-k
    function automatic logic slot_live(input logic [15:0] s, input logic [3:0] k);
        logic [3:0] b;
        b = 4'(14 - k);
        slot_live = s[b];
        if (b == `ALSEL_SEL_DIFF01) slot_live = s[12] && !s[14] && !s[13];
        if (b == `ALSEL_SEL_DIFF23) slot_live = s[9] && !s[11] && !s[10];
    endfunction
    function automatic logic [3:0] next_slot(input logic [15:0] s, input logic [3:0] from);
        next_slot = 4'hF;
        for (int k = 14; k >= 0; k--) begin
            if (4'(k) >= from && slot_live(s, 4'(k))) next_slot = 4'(k);
        end
    endfunction
    // channel number for the select bit that slot k walks
    function automatic logic [3:0] chan_of(input logic [3:0] k);
        logic [3:0] b;
        b = 4'(14 - k);
        if (b == 4'd14 || b == 4'd12) chan_of = 4'd0;
        else if (b == 4'd13) chan_of = 4'd1;
        else if (b == 4'd11 || b == 4'd9) chan_of = 4'd2;
        else if (b == 4'd10) chan_of = 4'd3;
        else chan_of = 4'(12 - b);
    endfunction

    logic start_d, start_q, busy_d, busy_q, diff_d, diff_q;
    logic [3:0] pos_d, pos_q, neg_d, neg_q;
    always_comb begin
        st_d = st_q;
        slot_d = slot_q;
        start_d = 1'b0;
        pos_d = pos_q;
        neg_d = neg_q;
        diff_d = diff_q;
        unique case (st_q)
            ALSEL_IDLE: begin
                if (ctl_q[`ALSEL_CTRL_START] && next_slot(sel_q, 4'h0) != 4'hF) begin
                    slot_d = next_slot(sel_q, 4'h0);
                    st_d = ALSEL_SCAN;
                end
            end
            ALSEL_SCAN: begin
                diff_d = (4'(14 - slot_q) == 4'd12) || (4'(14 - slot_q) == 4'd9);
                pos_d = chan_of(slot_q);
                neg_d = diff_d ? 4'(chan_of(slot_q) + 4'd1) : 4'h0;
                start_d = 1'b1;
                st_d = ALSEL_WAIT;
            end
            ALSEL_WAIT: begin
                if (CONV_DONE) begin
                    if (slot_q == 4'd14 || next_slot(sel_q, 4'(slot_q + 4'd1)) == 4'hF) begin
                        st_d = ALSEL_IDLE;
                    end else begin
                        slot_d = next_slot(sel_q, 4'(slot_q + 4'd1));
                        st_d = ALSEL_SCAN;
                    end
                end
            end
            default: st_d = ALSEL_IDLE;
        endcase
        busy_d = st_d != ALSEL_IDLE;
    end
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            st_q <= ALSEL_IDLE;
            slot_q <= 4'h0;
            start_q <= 1'b0;
            busy_q <= 1'b0;
            pos_q <= 4'h0;
            neg_q <= 4'h0;
            diff_q <= 1'b0;
        end else begin
            st_q <= st_d;
            slot_q <= slot_d;
            start_q <= start_d;
            busy_q <= busy_d;
            pos_q <= pos_d;
            neg_q <= neg_d;
            diff_q <= diff_d;
        end
    end

    // result storage: binary zero-extended, differential sign-extended
    logic [15:0] data_d [0:12];
    always_comb begin
        data_d = data_q;
        if (st_q == ALSEL_WAIT && CONV_DONE) begin
            if (diff_q) begin
                data_d[pos_q] = {{4{CONV_RESULT[11]}}, CONV_RESULT};
            end else begin
                data_d[pos_q] = {4'h0, CONV_RESULT};
            end
        end
    end
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            for (int i = 0; i < 13; i++) data_q[i] <= 16'h0000;
        end else begin
            data_q <= data_d;
        end
    end

    assign CONV_START = start_q;
    assign CONV_POS = pos_q;
    assign CONV_NEG = neg_q;
    assign CONV_DIFF = diff_q;
    assign SEQ_BUSY = busy_q;
endmodule

// >>> sim/alsel_chk.sv
// concurrent checks on the register bus and converter handshake of the alarm/select block
// assumes it is bound to alsel_top and sees only that module's ports
`timescale 1ns/1ns
module alsel_chk (
    // clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // register bus
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    // converter side
    input wire logic CONV_START,
    input wire logic [3:0] CONV_POS,
    input wire logic [3:0] CONV_NEG,
    input wire logic CONV_DIFF,
    input wire logic SEQ_BUSY
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    wire logic rd_ack = WB_ACK_O && !WB_WE_I;
    property p_ack_next; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
    a_ack_next: assert property (p_ack_next) else $error("bus request not acked");
    property p_ack_idle; !(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O; endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
    property p_sel_rsvd; rd_ack && WB_ADR_I == 8'h50 |-> WB_DAT_O[31:15] == 17'h0; endproperty
    a_sel_rsvd: assert property (p_sel_rsvd) else $error("select bit 15 reads one");
    property p_stat_rsvd;
        rd_ack && WB_ADR_I == 8'h4F |-> WB_DAT_O[1:0] == 2'h0 && WB_DAT_O[31:9] == 23'h0;
    endproperty
    a_stat_rsvd: assert property (p_stat_rsvd) else $error("status spare bits set");
    property p_start_gap; CONV_START |=> !CONV_START [*2]; endproperty
    a_start_gap: assert property (p_start_gap) else $error("start pulses too close");
    property p_start_busy; CONV_START |-> SEQ_BUSY; endproperty
    a_start_busy: assert property (p_start_busy) else $error("start while not busy");
    property p_pos_hold; SEQ_BUSY && !CONV_START |-> $stable(CONV_POS) && $stable(CONV_DIFF);
    endproperty
    a_pos_hold: assert property (p_pos_hold) else $error("channel moved inside slot");
    property p_single_neg; CONV_START && !CONV_DIFF |-> CONV_NEG == 4'h0; endproperty
    a_single_neg: assert property (p_single_neg) else $error("single slot has neg");
    property p_diff_pair;
        CONV_START && CONV_DIFF |->
            (CONV_POS == 4'h0 && CONV_NEG == 4'h1) || (CONV_POS == 4'h2 && CONV_NEG == 4'h3);
    endproperty
    a_diff_pair: assert property (p_diff_pair) else $error("bad pair");
endmodule
bind alsel_top alsel_chk u_chk (.CLK(CLK), .NRST(NRST), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .CONV_START(CONV_START), .CONV_POS(CONV_POS),
    .CONV_NEG(CONV_NEG), .CONV_DIFF(CONV_DIFF), .SEQ_BUSY(SEQ_BUSY));

// >>> sim/tb_top.sv
// self-checking bench for the alarm/select block
// assumes alsel_top with its bus acked one cycle after the taken edge
`timescale 1ns/1ns
module tb_top;
    logic CLK, NRST, WB_CYC_I, WB_STB_I, WB_WE_I, SENSE_STROBE, CONV_DONE;
    logic WB_ACK_O, CONV_START, CONV_DIFF, SEQ_BUSY;
    logic [7:0] WB_ADR_I;
    logic [3:0] WB_SEL_I, CONV_POS, CONV_NEG;
    logic [31:0] WB_DAT_I, WB_DAT_O;
    logic [11:0] DIE_TEMP, CONV_RESULT;
    // sensor pins in status bit order 8 down to 3
    logic [5:0] pins;
    logic [15:0] rd;
    int failures, n_compared, n_starts;
    alsel_top u_dut (.CLK(CLK), .NRST(NRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
        .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
        .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .SENSE_STROBE(SENSE_STROBE),
        .A_UNDER(pins[5]), .A_OVER(pins[4]), .B_UNDER(pins[3]), .B_OVER(pins[2]),
        .A_FAULT(pins[1]), .B_FAULT(pins[0]), .DIE_TEMP(DIE_TEMP), .CONV_START(CONV_START),
        .CONV_POS(CONV_POS), .CONV_NEG(CONV_NEG), .CONV_DIFF(CONV_DIFF),
        .CONV_DONE(CONV_DONE), .CONV_RESULT(CONV_RESULT), .SEQ_BUSY(SEQ_BUSY));
    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    always @(posedge CLK) if (CONV_START === 1'b1) n_starts++;
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] adr, input logic [15:0] wd);
        int n;
        n = 0;
        @(posedge CLK);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I <= we;
        WB_ADR_I <= adr;
        WB_DAT_I <= {16'h0000, wd};
        do begin
            @(posedge CLK);
            n++;
        end while (WB_ACK_O !== 1'b1 && n < 20);
        if (n >= 20) chk(16'hDEAD, 16'h0000);
        rd = WB_DAT_O[15:0];
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        WB_WE_I <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic rd_chk(input logic [7:0] adr, input logic [15:0] exp);
        wb(1'b0, adr, 16'h0000);
        chk(rd, exp);
    endtask
    task automatic sense(input int n);
        repeat (n) begin
            @(posedge CLK);
            SENSE_STROBE <= 1'b1;
            repeat (2) @(posedge CLK);
            SENSE_STROBE <= 1'b0;
            repeat (4) @(posedge CLK);
        end
    endtask
    // answers one converter slot after checking the channel it asked for
    task automatic slot(input logic [3:0] p, input logic [3:0] n, input logic d,
                        input logic [11:0] res);
        int k;
        k = 0;
        while (CONV_START !== 1'b1 && k < 50) begin
            @(posedge CLK);
            k++;
        end
        chk({7'h00, CONV_DIFF, CONV_NEG, CONV_POS}, {7'h00, d, n, p});
        CONV_DONE <= 1'b1;
        CONV_RESULT <= res;
        @(posedge CLK);
        CONV_DONE <= 1'b0;
    endtask
    task automatic t_regs;
        wb(1'b1, 8'h4F, 16'hFFFF);
        rd_chk(8'h4F, 16'h0000);
        rd_chk(8'h50, 16'h0000);
        rd_chk(8'h3F, 16'h0000);
        wb(1'b1, 8'h50, 16'hFFFF);
        rd_chk(8'h50, 16'h7FFF);
        WB_SEL_I <= 4'h1;
        wb(1'b1, 8'h50, 16'h0000);
        WB_SEL_I <= 4'h3;
        rd_chk(8'h50, 16'h7F00);
        $display("test registers done");
    endtask
    task automatic t_alarms;
        wb(1'b1, 8'h60, 16'h0001);
        pins <= 6'h24;
        sense(3);
        rd_chk(8'h4F, 16'h0000);
        sense(1);
        rd_chk(8'h4F, 16'h0100);
        pins <= 6'h00;
        sense(1);
        rd_chk(8'h4F, 16'h0100);
        rd_chk(8'h4F, 16'h0000);
        wb(1'b1, 8'h60, 16'h000A);
        pins <= 6'h32;
        sense(4);
        rd_chk(8'h4F, 16'h0000);
        wb(1'b1, 8'h60, 16'h000B);
        for (int i = 0; i < 6; i++) begin
            pins <= 6'h20 >> i;
            sense(4);
            rd_chk(8'h4F, 16'h0100 >> i);
            pins <= 6'h00;
            repeat (4) @(posedge CLK);
            rd_chk(8'h4F, 16'h0000);
        end
        $display("test sensor alarms done");
    endtask
    task automatic t_die;
        logic [11:0] temps [4] = '{12'd149, 12'd150, 12'd143, 12'd142};
        logic [15:0] exps [4] = '{16'h0000, 16'h0004, 16'h0004, 16'h0000};
        wb(1'b1, 8'h60, 16'h000C);
        for (int i = 0; i < 4; i++) begin
            DIE_TEMP <= temps[i];
            sense(4);
            rd_chk(8'h4F, exps[i]);
        end
        wb(1'b1, 8'h60, 16'h0008);
        DIE_TEMP <= 12'd150;
        sense(4);
        rd_chk(8'h4F, 16'h0000);
        $display("test die alarm done");
    endtask
    task automatic t_conv;
        wb(1'b1, 8'h50, 16'h5201);
        wb(1'b1, 8'h60, 16'h0010);
        slot(4'h0, 4'h0, 1'b0, 12'h123);
        slot(4'h2, 4'h3, 1'b1, 12'hF00);
        slot(4'hC, 4'h0, 1'b0, 12'hABC);
        rd_chk(8'h70, 16'h0123);
        rd_chk(8'h72, 16'hFF00);
        rd_chk(8'h7C, 16'h0ABC);
        wb(1'b1, 8'h50, 16'h1A00);
        wb(1'b1, 8'h60, 16'h0010);
        slot(4'h0, 4'h1, 1'b1, 12'h801);
        slot(4'h2, 4'h0, 1'b0, 12'h456);
        rd_chk(8'h70, 16'hF801);
        rd_chk(8'h72, 16'h0456);
        wb(1'b1, 8'h50, 16'h0000);
        wb(1'b1, 8'h60, 16'h0010);
        repeat (10) @(posedge CLK);
        chk(n_starts[15:0], 16'h0005);
        chk({15'h0000, SEQ_BUSY}, 16'h0000);
        $display("test conversions done");
    endtask
    initial begin
        {NRST, WB_CYC_I, WB_STB_I, WB_WE_I, SENSE_STROBE, CONV_DONE} = 6'h00;
        WB_ADR_I = 8'h00;
        WB_SEL_I = 4'h3;
        WB_DAT_I = 32'h0;
        DIE_TEMP = 12'h000;
        CONV_RESULT = 12'h000;
        pins = 6'h00;
        repeat (20) @(posedge CLK);
        NRST <= 1'b1;
        t_regs;
        t_alarms;
        t_die;
        t_conv;
        end_sim;
    end
    initial begin
        #(20 * 20000);
        failures++;
        end_sim;
    end
endmodule
